// *** inc/csm_map.vh ***
`ifndef CSM_MAP_VH
`define CSM_MAP_VH
`define CSM_ADDR_W        4
`define CSM_OFS_CARH      4'h0
`define CSM_OFS_CARL      4'h1
`define CSM_OFS_CON       4'h2
`define CSM_OFS_SRC       4'h3
`define CSM_PIN_DRV_OFF   7
`define CSM_INVERT        6
`define CSM_EDGE_SYNC     5
`define CSM_SEL_HI        3
`define CSM_SEL_LO        0
`define CSM_CAR_MASK      8'hef
`define CSM_CAR_RST       8'h00
`define CSM_CON_EN        7
`define CSM_CON_OE        6
`define CSM_CON_SLR       5
`define CSM_CON_OPOL      4
`define CSM_CON_OUT       3
`define CSM_CON_BIT       0
`define CSM_CON_MASK      8'hf1
`define CSM_CON_RST       8'h20
`define CSM_SRC_ODIS      7
`define CSM_SRC_MASK      8'h8f
`define CSM_SRC_RST       8'h00
`define CSM_SEL_GND       4'h0
`define CSM_SEL_PIN_A     4'h1
`define CSM_SEL_PIN_B     4'h2
`define CSM_SEL_REFCLK    4'h3
`define CSM_SEL_PWM1      4'h4
`define CSM_SEL_PWM2      4'h5
`define CSM_SEL_PWM3      4'h6
`define CSM_SEL_PWM4      4'h7
`define CSM_MS_BIT        4'h0
`define CSM_MS_PIN        4'h1
`define CSM_MS_PWM1       4'h2
`define CSM_MS_PWM2       4'h3
`define CSM_MS_PWM3       4'h4
`define CSM_MS_PWM4       4'h5
`define CSM_MS_CMP1       4'h6
`define CSM_MS_CMP2       4'h7
`define CSM_MS_SDO1       4'h8
`define CSM_MS_SDO2       4'h9
`define CSM_MS_TX         4'ha
`endif

// *** logic/csm_sync2.v ***
`timescale 1ns/1ps
module csm_sync2 #(
  parameter W = 8
) (
  input  wire         sys_clk,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_reg;
  // first stage read only by second
  always @(posedge sys_clk) begin
    meta_reg <= d;
    q        <= meta_reg;
  end
endmodule

// *** logic/csm_carrier_path.v ***
`timescale 1ns/1ps
`include "csm_map.vh"
module csm_carrier_path (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire [7:0] ctrl,
  input  wire [7:0] sources,
  output wire       carrier,
  output reg        fell,
  output wire [7:0] pin_drive_off
);
  wire [3:0] sel;
  wire       raw;
  reg        prev_reg;
  assign sel = ctrl[`CSM_SEL_HI:`CSM_SEL_LO];
  assign raw = sel[3] ? 1'b0 : sources[sel[2:0]];
  assign carrier = raw ^ ctrl[`CSM_INVERT];
  always @(posedge sys_clk) begin
    if (srst) begin
      prev_reg <= 1'b0;
      fell     <= 1'b0;
    end else begin
      prev_reg <= carrier;
      fell     <= 1'b0;
      if (prev_reg && !carrier) begin
        fell <= 1'b1;
      end
    end
  end
  // selected peripheral pin cut
  // ground has no peripheral, so no pin to cut
  assign pin_drive_off = (ctrl[`CSM_PIN_DRV_OFF] && !sel[3] && sel != `CSM_SEL_GND) ? (8'h01 << sel[2:0]) : 8'h00;
endmodule

// *** logic/csm_carrier_select_sync.v ***
`timescale 1ns/1ps
`include "csm_map.vh"
// Contract
// - high select: 0 ground, 1/2 carrier pins, 3 reference clock, 4-7 pwm units
// - high select codes 8 to 15 connect no source
// - low select in bits 3:0 uses the same encoding
// - high invert bit 6 inverts the selected high carrier
// - low invert bit 6 inverts the selected low carrier
// - high sync bit 5 delays high-to-low switch until high carrier falls
// - low sync bit 5 delays low-to-high switch until low carrier falls
// - sync clear switches carriers immediately, spurs accepted
// - high pin drive off bit 7 cuts selected peripheral pin drive
// - low pin drive off bit 7 cuts selected peripheral pin drive
// - bit 4 of both carrier registers reads zero
// - carrier fields hold over non-power resets
// - mixer passes high carrier on modulator one, low on zero
// - any reset disables the modulator, no mixed output
module csm_carrier_select_sync (
  input  wire                   sys_clk,
  input  wire                   srst,
  input  wire [`CSM_ADDR_W-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  input  wire [3:0]             avs_byteenable,
  output reg  [31:0]            avs_readdata,
  output reg                    avs_waitrequest,
  input  wire                   carrier_input_pin_a,
  input  wire                   carrier_input_pin_b,
  input  wire                   reference_clock_signal,
  input  wire                   pwm_unit_one_output,
  input  wire                   pwm_unit_two_output,
  input  wire                   pwm_unit_three_output,
  input  wire                   pwm_unit_four_output,
  input  wire                   modulator_pin_input,
  input  wire                   comparator_one_output,
  input  wire                   comparator_two_output,
  input  wire                   serial_data_out_one,
  input  wire                   serial_data_out_two,
  input  wire                   uart_tx_output,
  output reg                    modulator_out,
  output reg                    modulator_out_slew_limit,
  output reg  [7:0]             peripheral_pin_drive_off
);
  reg  [7:0]  high_carrier_control_reg;
  reg  [7:0]  low_carrier_control_reg;
  reg  [7:0]  modulator_control_reg;
  reg  [7:0]  modulator_source_control_reg;
  reg         use_high_reg;
  reg         mix_reg;
  reg         ack_reg;
  reg  [31:0] rdata_next;
  reg         mod_sig;
  wire [12:0] async_in;
  wire [12:0] sync_in;
  wire [7:0]  sources;
  wire        high_carrier;
  wire        low_carrier;
  wire        high_fell;
  wire        low_fell;
  wire [7:0]  high_off;
  wire [7:0]  low_off;
  wire        wr_hit;
  wire [3:0]  ms_sel;
  wire        cur_carrier;

  assign async_in = {uart_tx_output, serial_data_out_two, serial_data_out_one,
                     comparator_two_output, comparator_one_output, modulator_pin_input,
                     pwm_unit_four_output, pwm_unit_three_output, pwm_unit_two_output,
                     pwm_unit_one_output, reference_clock_signal,
                     carrier_input_pin_b, carrier_input_pin_a};

  // pins and foreign clocks cross in here
  csm_sync2 #(.W(13)) u_sync (
    .sys_clk (sys_clk),
    .d       (async_in),
    .q       (sync_in)
  );

  assign sources = {sync_in[6:0], 1'b0};

  csm_carrier_path u_high (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .ctrl          (high_carrier_control_reg),
    .sources       (sources),
    .carrier       (high_carrier),
    .fell          (high_fell),
    .pin_drive_off (high_off)
  );

  csm_carrier_path u_low (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .ctrl          (low_carrier_control_reg),
    .sources       (sources),
    .carrier       (low_carrier),
    .fell          (low_fell),
    .pin_drive_off (low_off)
  );

  assign ms_sel = modulator_source_control_reg[3:0];
  assign cur_carrier = use_high_reg ? high_carrier : low_carrier;

  always @* begin
    case (ms_sel)
      `CSM_MS_BIT:  mod_sig = modulator_control_reg[`CSM_CON_BIT];
      `CSM_MS_PIN:  mod_sig = sync_in[7];
      `CSM_MS_PWM1: mod_sig = sync_in[3];
      `CSM_MS_PWM2: mod_sig = sync_in[4];
      `CSM_MS_PWM3: mod_sig = sync_in[5];
      `CSM_MS_PWM4: mod_sig = sync_in[6];
      `CSM_MS_CMP1: mod_sig = sync_in[8];
      `CSM_MS_CMP2: mod_sig = sync_in[9];
      `CSM_MS_SDO1: mod_sig = sync_in[10];
      `CSM_MS_SDO2: mod_sig = sync_in[11];
      `CSM_MS_TX:   mod_sig = sync_in[12];
      default:      mod_sig = 1'b0;
    endcase
  end

  // write lands on the edge that answers
  assign wr_hit = avs_write && ack_reg && avs_byteenable[0];

  function [7:0] merge;
    input [7:0] old;
    input [7:0] wd;
    input [7:0] mask;
    begin
      merge = (old & ~mask) | (wd & mask);
    end
  endfunction

  // carrier selection state, sync gated
  always @(posedge sys_clk) begin
    if (srst) begin
      use_high_reg <= 1'b0;
    end else if (mod_sig && !use_high_reg) begin
      if (!low_carrier_control_reg[`CSM_EDGE_SYNC] || low_fell) begin
        use_high_reg <= 1'b1;
      end
    end else if (!mod_sig && use_high_reg) begin
      if (!high_carrier_control_reg[`CSM_EDGE_SYNC] || high_fell) begin
        use_high_reg <= 1'b0;
      end
    end
  end

  // carrier registers keep value on srst
  always @(posedge sys_clk) begin
    if (wr_hit && avs_address == `CSM_OFS_CARH) begin
      high_carrier_control_reg <= avs_writedata[7:0] & `CSM_CAR_MASK;
    end
    if (wr_hit && avs_address == `CSM_OFS_CARL) begin
      low_carrier_control_reg <= avs_writedata[7:0] & `CSM_CAR_MASK;
    end
    if (wr_hit && avs_address == `CSM_OFS_SRC) begin
      modulator_source_control_reg <= avs_writedata[7:0] & `CSM_SRC_MASK;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      modulator_control_reg <= `CSM_CON_RST;
    end else if (wr_hit && avs_address == `CSM_OFS_CON) begin
      modulator_control_reg <= merge(modulator_control_reg, avs_writedata[7:0], `CSM_CON_MASK);
    end
  end

  always @* begin
    rdata_next = 32'h0000_0000;
    case (avs_address)
      `CSM_OFS_CARH: rdata_next[7:0] = high_carrier_control_reg & `CSM_CAR_MASK;
      `CSM_OFS_CARL: rdata_next[7:0] = low_carrier_control_reg & `CSM_CAR_MASK;
      `CSM_OFS_CON:  rdata_next[7:0] = (modulator_control_reg & `CSM_CON_MASK)
                                       | {4'h0, mix_reg, 3'h0};
      `CSM_OFS_SRC:  rdata_next[7:0] = modulator_source_control_reg & `CSM_SRC_MASK;
      default:       rdata_next = 32'h0000_0000;
    endcase
  end

  // one wait cycle, answer on second edge
  always @(posedge sys_clk) begin
    if (srst) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      ack_reg         <= (avs_read || avs_write) && !ack_reg;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
      if (avs_read && !ack_reg) begin
        avs_readdata <= rdata_next;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      mix_reg                  <= 1'b0;
      modulator_out            <= 1'b0;
      modulator_out_slew_limit <= 1'b1;
      peripheral_pin_drive_off <= 8'h00;
    end else begin
      mix_reg <= modulator_control_reg[`CSM_CON_EN] & cur_carrier;
      modulator_out <= modulator_control_reg[`CSM_CON_EN] && modulator_control_reg[`CSM_CON_OE] &&
                       (cur_carrier ^ modulator_control_reg[`CSM_CON_OPOL]);
      modulator_out_slew_limit <= modulator_control_reg[`CSM_CON_SLR];
      peripheral_pin_drive_off <= high_off | low_off |
        ((modulator_source_control_reg[`CSM_SRC_ODIS] && ms_sel >= `CSM_MS_PWM1 && ms_sel <= `CSM_MS_PWM4)
         ? (8'h10 << (ms_sel - `CSM_MS_PWM1)) : 8'h00);
    end
  end
endmodule

// *** testbench/csm_src_model.sv ***
`timescale 1ns/1ps
module csm_src_model (
  input  wire       sys_clk,
  input  wire [6:0] level,
  output reg  [6:0] src
);
  // peripherals change only on the clock edge
  initial src = 7'h00;
  always @(posedge sys_clk) begin
    src <= level;
  end
endmodule

// *** testbench/csm_asserts.sv ***
`timescale 1ns/1ps
module csm_asserts (
  input wire        sys_clk,
  input wire        srst,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        modulator_out,
  input wire        modulator_out_slew_limit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_reset_wait: assert property ($fell(srst) |-> avs_waitrequest)
    else $error("waitrequest low after reset");
  a_reset_quiet: assert property ($fell(srst) |-> !modulator_out [*2])
    else $error("mixed output active after reset");
  a_reset_slew: assert property ($fell(srst) |-> modulator_out_slew_limit)
    else $error("slew limit clear after reset");
  a_answer_next: assert property (($rose(avs_read) || $rose(avs_write)) |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  a_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property ((!avs_read && !avs_write) [*2] |-> avs_waitrequest)
    else $error("answer without request");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_bit4_zero: assert property (avs_read && !avs_waitrequest && avs_address < 4'h2 |-> !avs_readdata[4])
    else $error("carrier bit 4 reads one");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h3 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind csm_carrier_select_sync csm_asserts u_chk (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .modulator_out(modulator_out), .modulator_out_slew_limit(modulator_out_slew_limit));

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  reg         sys_clk;
  reg         srst;
  reg  [3:0]  adr;
  reg         rd_q;
  reg         wr_q;
  reg  [31:0] wd;
  reg  [3:0]  be;
  wire [31:0] rdata;
  wire        wait_q;
  reg  [6:0]  level;
  wire [6:0]  src;
  reg  [5:0]  msrc;
  wire        mout;
  wire [7:0]  doff;
  integer     fails;
  integer     checked;
  integer     seed;
  integer     k;
  integer     s;
  reg  [3:0]  p;
  reg  [7:0]  ctl;
  reg  [7:0]  rd;
  reg  [7:0]  exp_v;
  reg  [7:0]  regs [0:1];
  csm_src_model u_src (.sys_clk(sys_clk), .level(level), .src(src));
  csm_carrier_select_sync dut (.sys_clk(sys_clk), .srst(srst), .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_q), .carrier_input_pin_a(src[0]), .carrier_input_pin_b(src[1]),
    .reference_clock_signal(src[2]), .pwm_unit_one_output(src[3]), .pwm_unit_two_output(src[4]),
    .pwm_unit_three_output(src[5]), .pwm_unit_four_output(src[6]), .modulator_pin_input(msrc[0]),
    .comparator_one_output(msrc[1]), .comparator_two_output(msrc[2]), .serial_data_out_one(msrc[3]),
    .serial_data_out_two(msrc[4]), .uart_tx_output(msrc[5]), .modulator_out(mout),
    .modulator_out_slew_limit(), .peripheral_pin_drive_off(doff));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task wrap_up;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task cmp(input [8*9:1] nm, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [7:0] d);
    integer n;
    begin
      n = 0;
      @(posedge sys_clk);
      adr <= a;
      wd <= {24'h0, d};
      rd_q <= !w;
      wr_q <= w;
      @(posedge sys_clk);
      while (wait_q !== 1'b0 && n < 20) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      if (n == 20) begin
        fails = fails + 1;
        wrap_up;
      end
      rd = rdata[7:0];
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
  endtask
  // reserved codes add nothing: no source behind them
  function car(input [7:0] r);
    begin
      car = r[6] ^ ((r[3:0] > 4'h0 && r[3:0] < 4'h8) ? level[r[2:0] - 3'h1] : 1'b0);
    end
  endfunction
  initial begin
    srst = 1'b1;
    adr = 4'h0;
    rd_q = 1'b0;
    wr_q = 1'b0;
    wd = 32'h0;
    be = 4'h1;
    level = 7'h00;
    msrc = 6'h00;
    fails = 0;
    checked = 0;
    seed = 32'hb843;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
      s = $random(seed);
      regs[k % 2] = s[7:0];
      bus(1'b1, k % 2, regs[k % 2]);
      bus(1'b0, k % 2, 8'h00);
      cmp("carrier", regs[k % 2] & 8'hef, rd);
    end
    be <= 4'h0;
    bus(1'b1, 4'h0, ~regs[0]);
    be <= 4'h1;
    bus(1'b0, 4'h0, 8'h00);
    cmp("no_lane", regs[0] & 8'hef, rd);
    bus(1'b1, 4'h9, 8'h5a);
    bus(1'b0, 4'h9, 8'h00);
    cmp("unmapped", 8'h00, rd);
    bus(1'b1, 4'h2, 8'hc0);
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    bus(1'b0, 4'h2, 8'h00);
    cmp("control", 8'h20, rd);
    bus(1'b0, 4'h0, 8'h00);
    cmp("kept", regs[0] & 8'hef, rd);
    bus(1'b1, 4'h3, 8'h00);
    for (k = 0; k < 32; k = k + 1) begin
      s = $random(seed);
      p = {3'h0, k[4]};
      ctl = {s[7:6], 2'b00, k[3:0]};
      level <= s[14:8];
      msrc <= s[20:15];
      bus(1'b1, p, ctl);
      bus(1'b1, !p, 8'h00);
      bus(1'b1, 4'h2, {7'h60, !p[0]});
      repeat (4) @(posedge sys_clk);
      cmp("mix_out", {7'h0, car(ctl)}, {7'h0, mout});
      exp_v = (ctl[7] && ctl[3:0] > 4'h0 && ctl[3:0] < 4'h8) ? 8'h01 << ctl[2:0] : 8'h00;
      cmp("drive_off", exp_v, doff);
    end
    for (k = 0; k < 4; k = k + 1) begin
      p = {3'h0, k[1]};
      level <= 7'h01;
      bus(1'b1, p, {2'b00, k[0], 5'h01});
      bus(1'b1, !p, 8'h00);
      bus(1'b1, 4'h2, {7'h60, !p[0]});
      repeat (6) @(posedge sys_clk);
      bus(1'b1, 4'h2, {7'h60, p[0]});
      repeat (6) @(posedge sys_clk);
      cmp("sync_hold", {7'h0, k[0]}, {7'h0, mout});
      level <= 7'h00;
      repeat (6) @(posedge sys_clk);
      cmp("sync_done", 8'h00, {7'h0, mout});
    end
    // high path constant one, low path constant zero: output follows modulator
    bus(1'b1, 4'h0, 8'h40);
    bus(1'b1, 4'h1, 8'h00);
    bus(1'b1, 4'h2, 8'hc0);
    for (k = 1; k < 11; k = k + 1) begin
      s = $random(seed);
      level <= s[6:0];
      msrc <= s[12:7];
      bus(1'b1, 4'h3, {4'h0, k[3:0]});
      repeat (6) @(posedge sys_clk);
      exp_v = {7'h0, (k == 1) ? msrc[0] : ((k < 6) ? level[k + 1] : msrc[k - 5])};
      cmp("mod_src", exp_v, {7'h0, mout});
    end
    wrap_up;
  end
endmodule
